// ### rtl/instr_exec_pkg.sv
package instr_exec_pkg;
    // Instruction word width of the core
    localparam int IW = 10;
    // Opcodes of the decoded group
    localparam logic [9:0] OP_SKIP_T4 = 10'h283;
    localparam logic [9:0] OP_SYS_RESET = 10'h001;
    localparam logic [9:0] OP_SER_START = 10'h29e;
    // Bit-skip opcode: upper eight bits fixed, low two bits select j
    localparam logic [7:0] OP_SKIP_BIT_HI = 8'h08;
    // Position of the enable bit in interrupt control register two
    localparam int T4_EN_POS = 1;
    // APB register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INSTR = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_MEMWORD = 8'h14;
    // Reset values
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] MEMWORD_RST = 4'hF;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    // Cycles the software reset pulse is held
    localparam int SYS_RST_CYCLES = 4;
    // Interrupt status bits
    localparam int EV_SKIP = 0;
    localparam int EV_T4_CLR = 1;
    localparam int EV_SER = 2;
    localparam int EV_RST = 3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RESET = 2'b01
    } exec_state_t;
endpackage

// ### rtl/skip_reset_serial_instr_exec.sv
`timescale 1ns/1ps
// What this block does
// - Enable clear: skip when fourth-timer flag set
// - Taken timer skip clears the fourth-timer flag
// - Enable clear, flag clear: no skip
// - Enable set: instruction is a no-op
// - Serial start clears done flag, starts transfer
// - Skip when selected memory bit zero
// - Selected memory bit one: no skip
module skip_reset_serial_instr_exec (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer and serial unit side
    input wire logic fourth_timer_set,
    input wire logic serial_done_set,
    output logic fourth_timer_request_flag,
    output logic serial_done_flag,
    output logic serial_start,
    // Core side
    output logic skip_next,
    output logic sys_reset,
    output logic irq
);
    import instr_exec_pkg::*;

    typedef struct packed {
        // Bus answer
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        // Software visible registers
        logic [3:0] ctrl;
        logic [3:0] memword;
        logic [9:0] last_instr;
        logic [3:0] irq_st;
        logic [3:0] irq_mask;
        // Flags set by the timer and serial units
        logic timer_flag;
        logic ser_done;
        // Stage 0 and 1 synchronise, stage 2 remembers for the edge
        logic [2:0] timer_sync;
        logic [2:0] ser_sync;
        // Pulses and levels towards the core
        logic ser_start;
        logic skip;
        logic skip_sticky;
        logic irq;
        logic rst_trig;
    } state_t;
    state_t s_r, s_nxt;

    // Bus phase decode
    logic setup_ph;
    logic wr_acc;
    logic rd_setup;
    logic addr_hit;

    // Instruction decode
    logic [9:0] op;
    logic exec_now;
    logic is_skip_t4;
    logic is_sys_rst;
    logic is_ser_start;
    logic is_bit_skip;

    // Flag edges and skip conditions
    logic timer_rise;
    logic ser_rise;
    logic en_bit;
    logic sel_bit;
    logic t4_take;
    logic bit_take;

    // Event vector and read multiplexer
    logic [3:0] ev;
    logic [31:0] rd_word;

    // Software reset level from the stretcher
    logic sys_reset_r;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    // Read data is fetched in setup so it stands while pready is high
    assign rd_setup = setup_ph && !pwrite;
    assign addr_hit = (paddr == ADDR_CTRL)
        || (paddr == ADDR_INSTR)
        || (paddr == ADDR_STATUS)
        || (paddr == ADDR_IRQ_ST)
        || (paddr == ADDR_IRQ_MASK)
        || (paddr == ADDR_MEMWORD);

    assign op = pwdata[9:0];
    assign exec_now = wr_acc && (paddr == ADDR_INSTR);
    assign is_skip_t4 = exec_now && (op == OP_SKIP_T4);
    assign is_sys_rst = exec_now && (op == OP_SYS_RESET);
    assign is_ser_start = exec_now && (op == OP_SER_START);
    assign is_bit_skip = exec_now && (op[9:2] == OP_SKIP_BIT_HI);

    assign timer_rise = s_r.timer_sync[1] && !s_r.timer_sync[2];
    assign ser_rise = s_r.ser_sync[1] && !s_r.ser_sync[2];
    // Control bit 1 stands in for the interrupt enable of the fourth timer
    assign en_bit = s_r.ctrl[T4_EN_POS];
    assign sel_bit = s_r.memword[op[1:0]];
    // Enable set turns the timer skip into a no-op
    assign t4_take = is_skip_t4 && !en_bit && s_r.timer_flag;
    assign bit_take = is_bit_skip && !sel_bit;

    always_comb begin
        ev = 4'h0;
        ev[EV_SKIP] = t4_take || bit_take;
        ev[EV_T4_CLR] = t4_take;
        ev[EV_SER] = ser_rise;
        ev[EV_RST] = is_sys_rst;
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL: begin
                rd_word = {28'h000_0000, s_r.ctrl};
            end
            ADDR_INSTR: begin
                rd_word = {22'h00_0000, s_r.last_instr};
            end
            ADDR_STATUS: begin
                rd_word = {28'h000_0000, sys_reset_r, s_r.skip_sticky, s_r.ser_done,
                    s_r.timer_flag};
            end
            ADDR_IRQ_ST: begin
                rd_word = {28'h000_0000, s_r.irq_st};
            end
            ADDR_IRQ_MASK: begin
                rd_word = {28'h000_0000, s_r.irq_mask};
            end
            ADDR_MEMWORD: begin
                rd_word = {28'h000_0000, s_r.memword};
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.timer_sync = {s_r.timer_sync[1:0], fourth_timer_set};
        s_nxt.ser_sync = {s_r.ser_sync[1:0], serial_done_set};
        s_nxt.ser_start = 1'b0;
        s_nxt.skip = 1'b0;
        s_nxt.rst_trig = 1'b0;
        // Zero-wait slave: answer decided in setup, shown in the access cycle
        s_nxt.pready = setup_ph;
        s_nxt.pslverr = setup_ph && !addr_hit;
        if (rd_setup) begin
            s_nxt.prdata = rd_word;
        end
        if (exec_now) begin
            s_nxt.last_instr = op;
        end
        if (t4_take) begin
            s_nxt.skip = 1'b1;
            s_nxt.timer_flag = 1'b0;
        end
        // Flag clear or enable set: skip and flag left alone
        if (is_sys_rst) begin
            s_nxt.rst_trig = 1'b1;
        end
        if (is_ser_start) begin
            s_nxt.ser_done = 1'b0;
            s_nxt.ser_start = 1'b1;
        end
        if (is_bit_skip) begin
            s_nxt.skip = !sel_bit;
        end
        // Hardware set wins over an instruction clear in the same cycle
        if (timer_rise) begin
            s_nxt.timer_flag = 1'b1;
        end
        if (ser_rise) begin
            s_nxt.ser_done = 1'b1;
        end
        if (exec_now) begin
            s_nxt.skip_sticky = s_nxt.skip;
        end
        if (wr_acc) begin
            case (paddr)
                ADDR_CTRL: begin
                    s_nxt.ctrl = pwdata[3:0];
                end
                ADDR_IRQ_ST: begin
                    s_nxt.irq_st = s_r.irq_st & ~pwdata[3:0];
                end
                ADDR_IRQ_MASK: begin
                    s_nxt.irq_mask = pwdata[3:0];
                end
                ADDR_MEMWORD: begin
                    s_nxt.memword = pwdata[3:0];
                end
                default: begin
                    s_nxt.irq_mask = s_nxt.irq_mask;
                end
            endcase
        end
        // A new event beats a write-one-to-clear in the same cycle
        s_nxt.irq_st = s_nxt.irq_st | ev;
        if (sys_reset_r) begin
            // Core state reloads; interrupt status, bus answer and synchronisers keep running
            s_nxt.ctrl = CTRL_RST;
            s_nxt.memword = MEMWORD_RST;
            s_nxt.irq_mask = IRQ_MASK_RST;
            s_nxt.last_instr = 10'h000;
            s_nxt.timer_flag = 1'b0;
            s_nxt.ser_done = 1'b0;
            s_nxt.ser_start = 1'b0;
            s_nxt.skip = 1'b0;
            s_nxt.skip_sticky = 1'b0;
            s_nxt.rst_trig = 1'b0;
        end
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.memword <= MEMWORD_RST;
            s_r.irq_mask <= IRQ_MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Stretches the one-cycle trigger so the whole core sees the reset
    sys_reset_stretch #(
        .CYCLES(SYS_RST_CYCLES)
    ) u_rst (
        .pclk(pclk),
        .presetn(presetn),
        .trigger(s_r.rst_trig),
        .sys_reset_r(sys_reset_r)
    );

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign fourth_timer_request_flag = s_r.timer_flag;
    assign serial_done_flag = s_r.ser_done;
    assign serial_start = s_r.ser_start;
    assign skip_next = s_r.skip;
    assign sys_reset = sys_reset_r;
    assign irq = s_r.irq;
endmodule

// ### rtl/sys_reset_stretch.sv
`timescale 1ns/1ps
module sys_reset_stretch #(
    parameter int CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trigger,
    output logic sys_reset_r
);
    import instr_exec_pkg::*;
    typedef struct packed {
        logic [7:0] cnt;
        logic rst;
    } stretch_t;
    stretch_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (trigger) begin
            s_nxt.cnt = 8'(CYCLES);
            s_nxt.rst = 1'b1;
        end else if (s_r.cnt != 8'h00) begin
            s_nxt.cnt = s_r.cnt - 8'h01;
            s_nxt.rst = (s_r.cnt != 8'h01);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sys_reset_r = s_r.rst;
endmodule

// ### test/skip_reset_serial_instr_exec_asserts.sv
`timescale 1ns/1ps
module skip_reset_serial_instr_exec_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Flags and core side
    input wire logic fourth_timer_request_flag,
    input wire logic serial_done_flag,
    input wire logic serial_start,
    input wire logic skip_next,
    input wire logic sys_reset
);
    import instr_exec_pkg::*;
    logic en_r;
    logic [3:0] mem_r;
    wire wr = psel && penable && pready && pwrite;
    wire op_wr = wr && paddr == ADDR_INSTR;
    wire t4 = op_wr && pwdata[9:0] == OP_SKIP_T4;
    wire bit_op = op_wr && pwdata[9:2] == OP_SKIP_BIT_HI;
    // Mirror of enable and memory word; software reset reloads both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'h0;
            mem_r <= MEMWORD_RST;
        end else if (sys_reset) begin
            en_r <= 1'h0;
            mem_r <= MEMWORD_RST;
        end else if (wr && paddr == ADDR_CTRL) begin
            en_r <= pwdata[T4_EN_POS];
        end else if (wr && paddr == ADDR_MEMWORD) begin
            mem_r <= pwdata[3:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_T4_SKIP: assert property (t4 && !en_r && fourth_timer_request_flag |=> skip_next)
        else $error("timer flag skip missing");
    AST_T4_CLR: assert property (t4 && !en_r && fourth_timer_request_flag |=>
        !fourth_timer_request_flag) else $error("timer flag not cleared");
    AST_T4_NOSKIP: assert property (t4 && !en_r && !fourth_timer_request_flag |=> !skip_next)
        else $error("skip without timer flag");
    AST_T4_NOP: assert property (t4 && en_r |=> !skip_next && $stable(fourth_timer_request_flag))
        else $error("enabled timer skip not a no-op");
    AST_SER: assert property (op_wr && pwdata[9:0] == OP_SER_START |=>
        serial_start && !serial_done_flag) else $error("serial start wrong");
    AST_BIT_SKIP: assert property (bit_op && !mem_r[pwdata[1:0]] |=> skip_next)
        else $error("bit skip missing");
    AST_BIT_NOSKIP: assert property (bit_op && mem_r[pwdata[1:0]] |=> !skip_next)
        else $error("bit skip wrongly taken");
    AST_SOFTWARE_SYSTEM_RESET_OP: assert property (op_wr && pwdata[9:0] == OP_SYS_RESET |->
        ##[1:2] sys_reset [*4] ##1 !sys_reset) else $error("software reset pulse wrong");
    cover property (t4 && !en_r && fourth_timer_request_flag);
    cover property (bit_op && !mem_r[pwdata[1:0]]);
    cover property ($rose(sys_reset));
endmodule
bind skip_reset_serial_instr_exec skip_reset_serial_instr_exec_asserts chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .fourth_timer_request_flag,
    .serial_done_flag, .serial_start, .skip_next, .sys_reset);

// ### test/skip_reset_serial_instr_exec_tb_top.sv
`timescale 1ns/1ps
module skip_reset_serial_instr_exec_tb_top;
    import instr_exec_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00, lf = 8'h2B;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, fourth_timer_set = 0, serial_done_set = 0, irq;
    logic fourth_timer_request_flag, serial_done_flag, serial_start, skip_next, sys_reset;
    int errors = 0, n_tests = 0, cyc = 0;
    always #20 pclk = ~pclk;
    skip_reset_serial_instr_exec dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .fourth_timer_set, .serial_done_set,
        .fourth_timer_request_flag, .serial_done_flag, .serial_start, .skip_next,
        .sys_reset, .irq);
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic exp_skip(input logic [3:0] w, input logic [1:0] j);
        return !w[j];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Drives right after a rising edge; ends on the falling edge after the taking edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(negedge pclk);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic op(input logic [9:0] o);
        apb(1'h1, ADDR_INSTR, 32'(o));
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, ADDR_MEMWORD, 0);
        chk(rd, MEMWORD_RST);
        apb(1'h0, 8'h40, 0);
        chk({rd[30:0], err}, 1);
        op(OP_SKIP_T4);
        chk(skip_next, 0);
        // Flag is set through a two-flop synchroniser
        @(posedge pclk);
        fourth_timer_set <= 1'h1;
        wait_cyc(5);
        apb(1'h1, ADDR_CTRL, 2);
        op(OP_SKIP_T4);
        chk({skip_next, fourth_timer_request_flag}, 1);
        apb(1'h1, ADDR_CTRL, 0);
        op(OP_SKIP_T4);
        chk({skip_next, fourth_timer_request_flag}, 2);
        op(OP_SKIP_T4);
        chk(skip_next, 0);
        @(posedge pclk);
        serial_done_set <= 1'h1;
        wait_cyc(5);
        chk(serial_done_flag, 1);
        op(OP_SER_START);
        chk({serial_start, serial_done_flag}, 2);
        for (int i = 0; i < 12; i++) begin
            lf = lfsr(lf);
            apb(1'h1, ADDR_MEMWORD, 32'(lf[3:0]));
            op({OP_SKIP_BIT_HI, i[1:0]});
            chk(skip_next, exp_skip(lf[3:0], i[1:0]));
        end
        chk(irq, 0);
        apb(1'h1, ADDR_IRQ_MASK, 1);
        wait_cyc(2);
        chk(irq, 1);
        apb(1'h1, ADDR_IRQ_ST, 32'h0000_000F);
        wait_cyc(2);
        chk(irq, 0);
        apb(1'h1, ADDR_CTRL, 2);
        op(OP_SYS_RESET);
        wait_cyc(1);
        chk(sys_reset, 1);
        wait_cyc(10);
        chk(sys_reset, 0);
        apb(1'h0, ADDR_CTRL, 0);
        chk(rd, CTRL_RST);
        end_of_test();
    end
endmodule
